//--- verilog/sar_adc_pkg.sv
// Constants, register map and types of the SAR converter control block.
// Assumes a single 50 MHz system clock and an APB register bus.
package sar_adc_pkg;

  // Bus and data widths
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned RESULT_W = 10;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_RESULT_HIGH  = 8'h1E;
  localparam logic [7:0] IDX_PRIMARY_CTRL = 8'h1F;
  localparam logic [7:0] IDX_RESULT_LOW   = 8'h9E;
  localparam logic [7:0] IDX_PIN_CONFIG   = 8'h9F;
  localparam logic [7:0] IDX_INT_STATUS   = 8'hA0;
  localparam logic [7:0] IDX_INT_MASK     = 8'hA1;

  localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH  = {2'b00, IDX_RESULT_HIGH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY_CTRL = {2'b00, IDX_PRIMARY_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW   = {2'b00, IDX_RESULT_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PIN_CONFIG   = {2'b00, IDX_PIN_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS   = {2'b00, IDX_INT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK     = {2'b00, IDX_INT_MASK, 2'b00};

  // Field positions of the primary control register
  localparam int unsigned CTL_CLK_HI = 7;
  localparam int unsigned CTL_CLK_LO = 6;
  localparam int unsigned CTL_CH_HI  = 5;
  localparam int unsigned CTL_CH_LO  = 3;
  localparam int unsigned CTL_GO     = 2;
  localparam int unsigned CTL_ON     = 0;

  // Field positions of the pin configuration register
  localparam int unsigned CFG_JUSTIFY = 7;
  localparam int unsigned CFG_PCFG_HI = 3;

  // Reset values and writable masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hF9;
  localparam logic [7:0] CFG_WMASK  = 8'h8F;

  // Smaller package: channels 0..4 exist, pins above AN4 absent
  localparam logic [2:0] NUM_CH_SMALL    = 3'h5;
  localparam logic [7:0] SMALL_PIN_MASK  = 8'h1F;

  // Conversion clock divide counts in system clock cycles
  localparam logic [5:0] DIV2_CYCLES  = 6'h02;
  localparam logic [5:0] DIV8_CYCLES  = 6'h08;
  localparam logic [5:0] DIV32_CYCLES = 6'h20;

  // Conversion clock selection codes
  typedef enum logic [1:0] {
    CLK_DIV2  = 2'b00,
    CLK_DIV8  = 2'b01,
    CLK_DIV32 = 2'b10,
    CLK_RC    = 2'b11
  } conv_clk_t;

  // Bit sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CONV = 3'b010,
    SEQ_DONE = 3'b100
  } seq_state_t;

endpackage : sar_adc_pkg

//--- verilog/sar_bit_sequencer.sv
// Successive approximation bit sequencer, one result bit per tick.
// Assumes the comparator input reflects the trial code at each tick.
`timescale 1ns/1ps
module sar_bit_sequencer
  import sar_adc_pkg::*;
#(
  parameter int unsigned RES_W = RESULT_W
)(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             tick,
  input  wire logic             compare,
  output logic                  busy,
  output logic                  done,
  output logic [RES_W-1:0]      trial,
  output logic [RES_W-1:0]      result
);
  localparam int unsigned IDX_W = $clog2(RES_W);
  localparam logic [IDX_W-1:0] TOP_BIT = IDX_W'(RES_W - 1);

  seq_state_t       state;
  seq_state_t       next_state;
  logic [IDX_W-1:0] bit_sel;
  logic [IDX_W:0]   tick_count;

  // Current trial bit and the value once it is resolved
  wire             last_bit = (bit_sel == '0);
  wire [RES_W-1:0] cur_bit  = {{(RES_W-1){1'b0}}, 1'b1} << bit_sel;
  wire [RES_W-1:0] resolved = compare ? trial : (trial & ~cur_bit);
  wire             step     = (state == SEQ_CONV) & tick;

  assign busy = (state == SEQ_CONV);
  assign done = (state == SEQ_DONE);

  // State transitions
  always_comb begin
    case (state)
      SEQ_IDLE: next_state = start ? SEQ_CONV : SEQ_IDLE;
      SEQ_CONV: begin
        if (abort)
          next_state = SEQ_IDLE;
        else if (tick && last_bit)
          next_state = SEQ_DONE;
        else
          next_state = SEQ_CONV;
      end
      // A start in the completion cycle is taken at once, not lost
      SEQ_DONE: next_state = start ? SEQ_CONV : SEQ_IDLE;
      default:  next_state = SEQ_IDLE;
    endcase
  end

  // Trial register walks from the top bit downward
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state   <= SEQ_IDLE;
      trial   <= '0;
      bit_sel <= '0;
      result  <= '0;
    end else begin
      state <= next_state;
      if (start && state != SEQ_CONV) begin
        trial   <= {1'b1, {(RES_W-1){1'b0}}};
        bit_sel <= TOP_BIT;
      end else if (step) begin
        trial   <= resolved | (last_bit ? '0 : (cur_bit >> 1));
        bit_sel <= bit_sel - 1'b1;
        if (last_bit)
          result <= resolved;
      end
    end
  end

  // Helper count of ticks taken in one conversion
  always_ff @(posedge clock) begin
    if (!rst_n || state != SEQ_CONV)
      tick_count <= '0;
    else if (step)
      tick_count <= tick_count + 1'b1;
  end

  AST_TEN_TICKS: assert property (@(posedge clock) disable iff (!rst_n)
    done |-> tick_count == (IDX_W+1)'(RES_W))
    else $error("conversion did not take one tick per result bit");

endmodule : sar_bit_sequencer

//--- verilog/sar_adc_control.sv
// Control and sequencing of a 10-bit SAR converter behind an APB slave.
// Assumes an analog front end that follows CHANNEL_SEL, DAC_CODE and
// the reference selects, and a comparator answer on COMPARE_IN.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
)(
  input  wire logic                CLOCK,
  input  wire logic                RST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                SLEEP_MODE,
  input  wire logic                RC_TICK,
  input  wire logic                COMPARE_IN,
  output logic                     POWER_ON,
  output logic      [2:0]          CHANNEL_SEL,
  output logic                     CHANNEL_VALID,
  output logic                     SAMPLE_EN,
  output logic      [RESULT_W-1:0] DAC_CODE,
  output logic      [7:0]          ANALOG_PIN_EN,
  output logic                     REF_HIGH_EXT,
  output logic                     REF_LOW_EXT,
  output logic                     IRQ
);

  logic [7:0]          ctrl_reg;
  logic [7:0]          cfg_reg;
  logic                int_status;
  logic                int_mask;
  logic [5:0]          div_cnt;
  conv_clk_t           run_clk;
  logic [RESULT_W-1:0] result;
  logic                busy;
  logic                seq_done;
  logic [7:0]          pin_mask;
  logic                vref_hi;
  logic                vref_lo;

  // APB phase decode
  wire access    = PSEL & PENABLE;
  wire commit    = access & PREADY;
  wire wr_commit = commit & PWRITE;
  wire rd_commit = commit & ~PWRITE;
  wire answer    = access & ~PREADY;
  wire [7:0] wbyte = PWDATA[7:0];

  // Address decode
  wire sel_res_hi = (PADDR == ADDR_RESULT_HIGH);
  wire sel_ctrl   = (PADDR == ADDR_PRIMARY_CTRL);
  wire sel_res_lo = (PADDR == ADDR_RESULT_LOW);
  wire sel_cfg    = (PADDR == ADDR_PIN_CONFIG);
  wire sel_status = (PADDR == ADDR_INT_STATUS);
  wire sel_mask   = (PADDR == ADDR_INT_MASK);
  wire mapped     = sel_res_hi | sel_ctrl | sel_res_lo | sel_cfg |
                    sel_status | sel_mask;
  wire wr_ctrl    = wr_commit & sel_ctrl;
  wire wr_cfg     = wr_commit & sel_cfg;
  wire wr_mask    = wr_commit & sel_mask;
  wire rd_status  = rd_commit & sel_status;

  // Control fields
  wire       power_on = ctrl_reg[CTL_ON];
  wire [2:0] chan     = ctrl_reg[CTL_CH_HI:CTL_CH_LO];
  wire       justify  = cfg_reg[CFG_JUSTIFY];
  wire [1:0] wr_clk_field = wbyte[CTL_CLK_HI:CTL_CLK_LO];

  // Start and abort of a conversion through the go bit
  wire start_req = wr_ctrl & wbyte[CTL_GO] & wbyte[CTL_ON] &
                   power_on & ~busy;
  wire abort_wr  = wr_ctrl & ~(wbyte[CTL_GO] & wbyte[CTL_ON]);
  wire abort     = busy & (abort_wr | ~power_on);

  // Next register values; control bits 2 and 1 are never stored
  wire [7:0] next_ctrl = wr_ctrl ? (wbyte & CTRL_WMASK) : ctrl_reg;
  wire [7:0] next_cfg  = wr_cfg  ? (wbyte & CFG_WMASK)  : cfg_reg;
  wire next_mask       = wr_mask ? wbyte[0] : int_mask;
  // A completion in the same cycle as the clearing read is kept
  wire next_int_status = seq_done | (int_status & ~rd_status);

  // Channel availability depends on the package
  wire chan_ok = LARGE_PACKAGE || (chan < NUM_CH_SMALL);
  wire [7:0] pin_avail = LARGE_PACKAGE ? 8'hFF : SMALL_PIN_MASK;

  // Conversion clock: divided system clock or the RC oscillator tick
  wire [5:0] div_limit = (run_clk == CLK_DIV2)  ? DIV2_CYCLES :
                         (run_clk == CLK_DIV8)  ? DIV8_CYCLES :
                                                  DIV32_CYCLES;
  wire div_tick  = (div_cnt == div_limit - 6'h01);
  wire use_rc    = (run_clk == CLK_RC);
  // The system oscillator halts in sleep; only the RC tick keeps going
  wire conv_tick = use_rc ? RC_TICK : (div_tick & ~SLEEP_MODE);
  wire [5:0] next_div_cnt = !busy      ? 6'h00 :
                            SLEEP_MODE ? div_cnt :
                            div_tick   ? 6'h00 :
                                         div_cnt + 6'h01;

  // Readback of each register; narrow values sit in the low bits, except the left justified low result bits in bits 7:6
  wire [7:0] rd_ctrl   = {ctrl_reg[7:3], busy, 1'b0,
                          ctrl_reg[CTL_ON]};
  wire [7:0] rd_res_hi = justify ? {6'h00, result[9:8]} :
                                   result[9:2];
  wire [7:0] rd_res_lo = justify ? result[7:0] :
                                   {result[1:0], 6'h00};
  wire [7:0] rd_data   = sel_ctrl   ? rd_ctrl :
                         sel_res_hi ? rd_res_hi :
                         sel_res_lo ? rd_res_lo :
                         sel_cfg    ? cfg_reg :
                         sel_status ? {7'h00, int_status} :
                         sel_mask   ? {7'h00, int_mask} :
                                      8'h00;

  // Pin and reference configuration table
  always_comb begin
    case (cfg_reg[CFG_PCFG_HI:0])
      4'h0:    {pin_mask, vref_hi, vref_lo} = {8'hFF, 1'b0, 1'b0};
      4'h1:    {pin_mask, vref_hi, vref_lo} = {8'hF7, 1'b1, 1'b0};
      4'h2:    {pin_mask, vref_hi, vref_lo} = {8'h1F, 1'b0, 1'b0};
      4'h3:    {pin_mask, vref_hi, vref_lo} = {8'h17, 1'b1, 1'b0};
      4'h4:    {pin_mask, vref_hi, vref_lo} = {8'h0B, 1'b0, 1'b0};
      4'h5:    {pin_mask, vref_hi, vref_lo} = {8'h03, 1'b1, 1'b0};
      4'h6:    {pin_mask, vref_hi, vref_lo} = {8'h00, 1'b0, 1'b0};
      4'h7:    {pin_mask, vref_hi, vref_lo} = {8'h00, 1'b0, 1'b0};
      4'h8:    {pin_mask, vref_hi, vref_lo} = {8'hF3, 1'b1, 1'b1};
      4'h9:    {pin_mask, vref_hi, vref_lo} = {8'h3F, 1'b0, 1'b0};
      4'hA:    {pin_mask, vref_hi, vref_lo} = {8'h37, 1'b1, 1'b0};
      4'hB:    {pin_mask, vref_hi, vref_lo} = {8'h33, 1'b1, 1'b1};
      4'hC:    {pin_mask, vref_hi, vref_lo} = {8'h13, 1'b1, 1'b1};
      4'hD:    {pin_mask, vref_hi, vref_lo} = {8'h03, 1'b1, 1'b1};
      4'hE:    {pin_mask, vref_hi, vref_lo} = {8'h01, 1'b0, 1'b0};
      4'hF:    {pin_mask, vref_hi, vref_lo} = {8'h01, 1'b1, 1'b1};
      default: {pin_mask, vref_hi, vref_lo} = {8'h00, 1'b0, 1'b0};
    endcase
  end

  // Software registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl_reg   <= CTRL_RESET;
      cfg_reg    <= CFG_RESET;
      int_status <= 1'b0;
      int_mask   <= 1'b0;
    end else begin
      ctrl_reg   <= next_ctrl;
      cfg_reg    <= next_cfg;
      int_status <= next_int_status;
      int_mask   <= next_mask;
    end
  end

  // Conversion clock divider; select is frozen for each conversion
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      div_cnt <= 6'h00;
      run_clk <= CLK_DIV2;
    end else begin
      div_cnt <= next_div_cnt;
      if (start_req)
        run_clk <= conv_clk_t'(wr_clk_field);
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= answer;
      if (answer) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_data};
        PSLVERR <= ~mapped;
      end
    end
  end

  // Registered front end controls and interrupt line
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      CHANNEL_VALID <= 1'b0;
      SAMPLE_EN     <= 1'b0;
      ANALOG_PIN_EN <= 8'h00;
      REF_HIGH_EXT  <= 1'b0;
      REF_LOW_EXT   <= 1'b0;
      IRQ           <= 1'b0;
    end else begin
      CHANNEL_VALID <= chan_ok;
      SAMPLE_EN     <= power_on & chan_ok & ~busy;
      ANALOG_PIN_EN <= pin_mask & pin_avail;
      REF_HIGH_EXT  <= vref_hi;
      REF_LOW_EXT   <= vref_lo;
      IRQ           <= next_int_status & next_mask;
    end
  end

  assign POWER_ON    = power_on;
  assign CHANNEL_SEL = chan;

  // Successive approximation engine
  sar_bit_sequencer #(
    .RES_W   (RESULT_W)
  ) u_seq (
    .clock   (CLOCK),
    .rst_n   (RST_N),
    .start   (start_req),
    .abort   (abort),
    .tick    (conv_tick),
    .compare (COMPARE_IN),
    .busy    (busy),
    .done    (seq_done),
    .trial   (DAC_CODE),
    .result  (result)
  );

  // Checks on the control behaviour
  AST_UNUSED_BIT: assert property (@(posedge CLOCK) disable iff (!RST_N)
    answer && !PWRITE && sel_ctrl |=> !PRDATA[1])
    else $error("control bit 1 read back as one");

  AST_GO_STARTS: assert property (@(posedge CLOCK) disable iff (!RST_N)
    start_req |=> busy ##0 rd_ctrl[CTL_GO])
    else $error("go bit did not start a conversion");

  AST_DONE_CLEARS: assert property (@(posedge CLOCK) disable iff (!RST_N)
    busy ##1 !busy && !$past(abort) |-> seq_done && !rd_ctrl[CTL_GO])
    else $error("go bit fell without a completion");

  AST_DONE_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_N)
    seq_done |=> int_status && ($past(DAC_CODE) == result)
    ##0 $stable(result))
    else $error("completion did not raise the done flag");

  AST_SLEEP_HALT: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SLEEP_MODE && !use_rc |-> !conv_tick)
    else $error("conversion clock ran in sleep off the RC clock");

  AST_DIV8_GAP: assert property (@(posedge CLOCK) disable iff (!RST_N)
    div_tick && run_clk == CLK_DIV8 && busy |=> !div_tick [*7])
    else $error("divide by 8 ticked early");

  AST_JUSTIFY: assert property (@(posedge CLOCK) disable iff (!RST_N)
    answer && !PWRITE && sel_res_hi && justify |=> PRDATA[7:2] == 6'h00)
    else $error("right justified high byte not zero filled");

  AST_SMALL_CHAN: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !LARGE_PACKAGE && chan >= NUM_CH_SMALL |=> !CHANNEL_VALID)
    else $error("absent channel reported as valid");

  AST_POWER_OFF: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !power_on && busy |=> !busy)
    else $error("conversion kept running with the converter off");

  // Checks on start, flag, interrupt and bus answers
  AST_START_CLK: assert property (@(posedge CLOCK) disable iff (!RST_N)
    start_req |=> run_clk == conv_clk_t'($past(wr_clk_field)))
    else $error("conversion clock not taken from the starting write");

  AST_NO_START: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_ctrl && !power_on |=> !busy)
    else $error("conversion ran while the converter was off");

  AST_READ_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_N)
    rd_status && !seq_done |=> !int_status)
    else $error("status read did not clear the done flag");

  AST_DONE_PULSE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    seq_done |=> !seq_done)
    else $error("completion lasted more than one cycle");

  AST_IRQ_MASK: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !int_mask |-> !IRQ)
    else $error("interrupt raised while masked");

  AST_LEFT_JUST: assert property (@(posedge CLOCK) disable iff (!RST_N)
    answer && !PWRITE && sel_res_lo && !justify |=> PRDATA[5:0] == 6'h00)
    else $error("left justified low byte not zero filled");

  AST_BAD_ADDR: assert property (@(posedge CLOCK) disable iff (!RST_N)
    answer && !mapped |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not answered with an error");

endmodule : sar_adc_control

//--- verif/sar_analog_model.sv
// Behavioural analog front end: comparator and RC clock.
// Assumes the level input holds the sampled input voltage in codes.
`timescale 1ns/1ps
module sar_analog_model
  import sar_adc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                power_on,
  input  wire logic                channel_valid,
  input  wire logic [RESULT_W-1:0] dac_code,
  input  wire logic [RESULT_W-1:0] level,
  output logic                     compare_in,
  output logic                     rc_tick
);
  logic [1:0] rc_count;
  logic       toggle;

  // Free running RC oscillator, one tick every four system cycles while power_on is high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rc_count <= 2'h0;
      rc_tick  <= 1'b0;
      toggle   <= 1'b0;
    end else begin
      rc_count <= rc_count + 2'h1;
      rc_tick  <= power_on && (rc_count == 2'h3);
      toggle   <= ~toggle;
    end
  end

  // Comparator; unpowered or unconnected input gives a changing level
  always_comb begin
    if (power_on && channel_valid)
      compare_in = (level >= dac_code);
    else
      compare_in = toggle;
  end
endmodule : sar_analog_model

//--- verif/test_sar_adc_control.sv
// Self-checking bench of the SAR converter control block over APB.
// Assumes the analog model in the verif folder and the design package.
`timescale 1ns/1ps
module test_sar_adc_control
  import sar_adc_pkg::*;
;
  logic                clock = 1'b0;
  logic                rst_n;
  logic                psel, penable, pwrite, sleep_mode;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata, prdata;
  logic                pready, pslverr, rc_tick, compare_in;
  logic                power_on, channel_valid, sample_en, irq;
  logic                ref_high_ext, ref_low_ext;
  logic [2:0]          channel_sel;
  logic [RESULT_W-1:0] dac_code, level;
  logic [7:0]          analog_pin_en;
  logic                small_valid;
  logic [7:0]          small_pins;
  logic [32:0]         expq[$];
  logic [32:0]         e;
  logic [31:0]         seed = 32'h00008053;
  int                  mismatches = 0;
  int                  num_checks = 0;

  // Clock at 50 MHz
  always #10 clock = ~clock;

  sar_adc_control dut (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SLEEP_MODE(sleep_mode),
    .RC_TICK(rc_tick), .COMPARE_IN(compare_in), .POWER_ON(power_on),
    .CHANNEL_SEL(channel_sel), .CHANNEL_VALID(channel_valid),
    .SAMPLE_EN(sample_en), .DAC_CODE(dac_code),
    .ANALOG_PIN_EN(analog_pin_en), .REF_HIGH_EXT(ref_high_ext),
    .REF_LOW_EXT(ref_low_ext), .IRQ(irq));

  sar_analog_model partner (
    .clock(clock), .rst_n(rst_n), .power_on(power_on),
    .channel_valid(channel_valid), .dac_code(dac_code), .level(level),
    .compare_in(compare_in), .rc_tick(rc_tick));

  // Five channel variant on the same bus, watched for channels and pins
  sar_adc_control #(.LARGE_PACKAGE(1'b0)) dut_small (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
    .PREADY(), .PSLVERR(), .SLEEP_MODE(sleep_mode),
    .RC_TICK(rc_tick), .COMPARE_IN(compare_in), .POWER_ON(),
    .CHANNEL_SEL(), .CHANNEL_VALID(small_valid),
    .SAMPLE_EN(), .DAC_CODE(),
    .ANALOG_PIN_EN(small_pins), .REF_HIGH_EXT(),
    .REF_LOW_EXT(), .IRQ());

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for the answer; a hung transfer is ended by the watchdog
    do
      @(posedge clock);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [31:0] x,
                        input logic err);
    expq.push_back({err, x});
    apb(1'b0, a, 32'h0);
  endtask : rd_exp

  // Read results are compared when the access completes
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      chk({pslverr, prdata}, e);
    end
  end

  task automatic convert(input logic [1:0] cs, input logic just);
    logic [2:0] ch;
    logic [9:0] lv;
    int n, p;
    seed = xs(seed);
    ch = seed[2:0];
    lv = seed[17:8];
    level <= lv;
    p = (cs == 2'b00) ? 2 : (cs == 2'b01) ? 8 : (cs == 2'b10) ? 32 : 4;
    apb(1'b1, ADDR_PIN_CONFIG, {24'h0, just, 7'h00});
    apb(1'b1, ADDR_PRIMARY_CTRL, {24'h0, cs, ch, 3'b001});
    repeat (2) @(posedge clock);
    chk(33'({power_on, channel_sel, channel_valid, sample_en, small_valid}),
        33'({1'b1, ch, 1'b1, 1'b1, ch < 3'h5}));
    apb(1'b1, ADDR_PRIMARY_CTRL, {24'h0, cs, ch, 3'b101});
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    chk(33'(n >= 9 * p && n <= 10 * p + 4), 33'h1);
    chk(33'(dac_code), 33'(lv));
    rd_exp(ADDR_PRIMARY_CTRL, {24'h0, cs, ch, 3'b001}, 1'b0);
    rd_exp(ADDR_RESULT_HIGH,
           just ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]}, 1'b0);
    rd_exp(ADDR_RESULT_LOW,
           just ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h00},
           1'b0);
    rd_exp(ADDR_INT_STATUS, 32'h1, 1'b0);
    repeat (2) @(posedge clock);
    chk(33'(irq), 33'h0);
    rd_exp(ADDR_INT_STATUS, 32'h0, 1'b0);
    repeat (2 * p + 2) @(posedge clock);
  endtask : convert

  // Pin configuration codes and expected {pins, ref high, ref low}
  logic [3:0] pc [6] = '{4'h0, 4'h6, 4'hE, 4'h9, 4'h8, 4'h1};
  logic [9:0] pe [6] = '{10'h3FC, 10'h000, 10'h004, 10'h0FC, 10'h3CF,
                         10'h3DE};

  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sleep_mode = 1'b0;
    level = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    chk({power_on, irq, pready, pslverr, sample_en, dac_code, prdata[17:0]},
        33'h0);
    rd_exp(ADDR_PRIMARY_CTRL, 32'h0, 1'b0);
    rd_exp(ADDR_PIN_CONFIG, 32'h0, 1'b0);
    rd_exp(12'h000, 32'h0, 1'b1);
    apb(1'b1, ADDR_PRIMARY_CTRL, 32'hFF);
    rd_exp(ADDR_PRIMARY_CTRL, 32'hF9, 1'b0);
    apb(1'b1, ADDR_PIN_CONFIG, 32'hFF);
    rd_exp(ADDR_PIN_CONFIG, 32'h8F, 1'b0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADDR_PIN_CONFIG, {28'h0, pc[i]});
      repeat (2) @(posedge clock);
      chk(33'({analog_pin_en, ref_high_ext, ref_low_ext, small_pins}),
          33'({pe[i], pe[i][9:2] & 8'h1F}));
    end
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    for (int k = 0; k < 4; k++) convert(2'(k), k[0]);
    // Masked completion leaves the interrupt low
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    apb(1'b1, ADDR_PRIMARY_CTRL, 32'h05);
    repeat (60) @(posedge clock);
    chk(33'(irq), 33'h0);
    rd_exp(ADDR_INT_STATUS, 32'h1, 1'b0);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    // Sleep stalls the divided clock; abort with go cleared
    sleep_mode <= 1'b1;
    apb(1'b1, ADDR_PRIMARY_CTRL, 32'h45);
    repeat (300) @(posedge clock);
    rd_exp(ADDR_PRIMARY_CTRL, 32'h45, 1'b0);
    apb(1'b1, ADDR_PRIMARY_CTRL, 32'h41);
    rd_exp(ADDR_PRIMARY_CTRL, 32'h41, 1'b0);
    rd_exp(ADDR_INT_STATUS, 32'h0, 1'b0);
    convert(2'b11, 1'b1);
    // Channel 7 exists only on the large package
    apb(1'b1, ADDR_PRIMARY_CTRL, 32'h39);
    repeat (2) @(posedge clock);
    chk(33'({channel_valid, small_valid, channel_sel}), 33'h17);
    sleep_mode <= 1'b0;
    apb(1'b1, ADDR_PRIMARY_CTRL, 32'h00);
    repeat (2) @(posedge clock);
    chk(33'(power_on), 33'h0);
    report_and_stop();
  end

  // Watchdog against a hung bus or conversion
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
endmodule : test_sar_adc_control
